// File: dac_cmd_pkg.sv
/*
 * Shared constants and types for the eight-channel write/update command decoder:
 * frame field positions, command and address codes, register offsets and reset values.
 * Assumes 32-bit APB data and a 32-bit serial frame shifted in MSB first.
 */
package dac_cmd_pkg;

    localparam int FRAME_BITS = 32;
    localparam int NUM_CH = 8;
    localparam int CODE_W = 16;

    // frame field positions
    localparam int FRAME_TOP_BIT = 31;
    localparam int CMD_HI = 27;
    localparam int CMD_LO = 24;
    localparam int ADDR_HI = 23;
    localparam int ADDR_LO = 20;
    localparam int DATA_HI = 19;
    localparam int DATA16_LO = 4;
    localparam int DATA14_LO = 6;
    localparam int DATA12_LO = 8;
    localparam int FEAT_HI = 3;
    localparam int FEAT_LO = 0;

    // command nibble and address codes
    localparam logic [3:0] CMD_WRITE_UPDATE_ALL = 4'h2;
    localparam logic [3:0] CMD_WRITE_UPDATE_ONE = 4'h3;
    localparam logic [3:0] ADDR_BROADCAST = 4'hF;

    // register byte addresses
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_COUNTS = 8'h04;
    localparam logic [7:0] OFS_LAST_FRAME = 8'h08;
    localparam logic [7:0] OFS_INPUT_BASE = 8'h40;
    localparam logic [7:0] OFS_OUTPUT_BASE = 8'h60;

    // reset values
    localparam logic [1:0] RST_VARIANT = 2'h0;
    localparam logic [CODE_W-1:0] RST_CODE = 16'h0000;

    typedef enum logic [1:0] {
        VARIANT_16 = 2'h0,
        VARIANT_14 = 2'h1,
        VARIANT_12 = 2'h2
    } variant_t;

    typedef struct packed {
        logic top_bit;
        logic [3:0] cmd;
        logic [3:0] addr;
        logic [CODE_W-1:0] data;
        logic [3:0] feat;
    } frame_fields_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

endpackage : dac_cmd_pkg

// File: dac_write_update_decoder.sv
/*
 * Top of the write/update command decoder: takes frames from the link, decodes the two
 * write-and-update commands into eight input and output code registers, and exposes
 * control and status over an APB slave.
 * Assumes pclk and sclk are unrelated; frame words cross by toggle handshake.
 */
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// R1 - 16-bit frame: data in bits 19..4
// R2 - 14-bit frame: data in bits 19..6
// R3 - 12-bit frame: data in bits 19..8
// R4 - command 2: write channel, update all outputs
// R5 - address 0..7 selects channels A..H
// R6 - command 3: write and update one channel
// R7 - address 8..14: nothing changes
// R8 - address 15: write and update all
// R9 - feature bits 3..0 ignored
// R10 - act only on complete 32-bit frames
module dac_write_update_decoder
    import dac_cmd_pkg::*;
#(
    parameter int NUM_CHANNELS = NUM_CH
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire apb_req_t apb_req,
    output apb_rsp_t apb_rsp,
    input wire logic sclk,
    input wire logic sync_n,
    input wire logic sdin,
    output logic [NUM_CHANNELS-1:0][CODE_W-1:0] dac_code
);

    function automatic frame_fields_t split_frame(input logic [FRAME_BITS-1:0] w, input logic [1:0] variant);
        frame_fields_t f;
        f.top_bit = w[FRAME_TOP_BIT]; // [R1]
        f.cmd = w[CMD_HI:CMD_LO];
        f.addr = w[ADDR_HI:ADDR_LO];
        f.feat = w[FEAT_HI:FEAT_LO];
        unique case (variant)
            VARIANT_14: f.data = {2'b00, w[DATA_HI:DATA14_LO]}; // [R2]
            VARIANT_12: f.data = {4'h0, w[DATA_HI:DATA12_LO]}; // [R3]
            default: f.data = w[DATA_HI:DATA16_LO]; // [R1]
        endcase
        return f;
    endfunction : split_frame

    function automatic logic is_write_cmd(input logic [3:0] cmd);
        return (cmd == CMD_WRITE_UPDATE_ALL) || (cmd == CMD_WRITE_UPDATE_ONE);
    endfunction : is_write_cmd

    logic [FRAME_BITS-1:0] link_word;
    logic link_toggle;
    logic tog_s1_q;
    logic tog_s2_q;
    logic tog_s3_q;
    logic frame_evt;
    frame_fields_t fields;

    logic [1:0] variant_q;
    logic [15:0] applied_cnt_q;
    logic [15:0] rejected_cnt_q;
    logic [FRAME_BITS-1:0] last_frame_q;
    logic [NUM_CHANNELS-1:0][CODE_W-1:0] in_q;
    logic [NUM_CHANNELS-1:0][CODE_W-1:0] out_q;
    apb_rsp_t rsp_q;
    logic [31:0] rdata_d;
    logic err_d;
    logic setup_phase;
    logic access_done;
    logic do_write;
    logic addr_valid;
    logic addr_bcast;
    logic frame_ok;
    logic [2:0] ch_sel;

    frame_shifter u_shifter (
        .sclk(sclk),
        .presetn(presetn),
        .sync_n(sync_n),
        .sdin(sdin),
        .frame_word_q(link_word),
        .frame_toggle_q(link_toggle)
    );

    // toggle synchroniser; the third stage only serves edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tog_s1_q <= 1'b0;
            tog_s2_q <= 1'b0;
            tog_s3_q <= 1'b0;
        end else begin
            tog_s1_q <= link_toggle;
            tog_s2_q <= tog_s1_q;
            tog_s3_q <= tog_s2_q;
        end
    end

    // word is stable for many pclk cycles once the toggle edge is seen
    assign frame_evt = tog_s2_q ^ tog_s3_q; // [R10]
    assign fields = split_frame(link_word, variant_q);
    assign addr_valid = !fields.addr[3]; // [R5]
    assign addr_bcast = fields.addr == ADDR_BROADCAST; // [R8]
    assign ch_sel = fields.addr[2:0]; // [R5]
    // feature bits take no part in this decision
    assign frame_ok = frame_evt && !fields.top_bit && is_write_cmd(fields.cmd) && (addr_valid || addr_bcast); // [R9]

    // input registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_q <= '{default: RST_CODE};
        end else if (frame_ok) begin
            for (int i = 0; i < NUM_CHANNELS; i++) begin
                if (addr_bcast || ch_sel == 3'(i)) begin
                    in_q[i] <= fields.data; // [R4] [R6] [R8]
                end
            end
        end
    end

    // output registers take the freshly written value in the same step as the input register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_q <= '{default: RST_CODE};
        end else if (frame_ok) begin
            for (int i = 0; i < NUM_CHANNELS; i++) begin
                if (addr_bcast || ch_sel == 3'(i)) begin
                    out_q[i] <= fields.data; // [R6] [R8]
                end else if (fields.cmd == CMD_WRITE_UPDATE_ALL) begin
                    out_q[i] <= in_q[i]; // [R4]
                end
            end
        end
    end

    assign dac_code = out_q;

    // status: invalid address, set top bit and other commands count as rejected here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            applied_cnt_q <= 16'h0000;
            rejected_cnt_q <= 16'h0000;
            last_frame_q <= 32'h0000_0000;
        end else if (frame_evt) begin
            last_frame_q <= link_word;
            if (frame_ok) begin
                applied_cnt_q <= applied_cnt_q + 16'h0001;
            end else begin
                rejected_cnt_q <= rejected_cnt_q + 16'h0001; // [R7]
            end
        end
    end

    // APB slave: one wait-free access phase, answer registered at the setup edge
    assign setup_phase = apb_req.psel && !apb_req.penable;
    assign access_done = apb_req.psel && apb_req.penable && rsp_q.pready;
    assign do_write = access_done && apb_req.pwrite && !rsp_q.pslverr;

    always_comb begin
        rdata_d = 32'h0000_0000;
        err_d = 1'b0;
        if (apb_req.paddr[1:0] != 2'b00) begin
            err_d = 1'b1;
        end else if (apb_req.paddr == OFS_CTRL) begin
            rdata_d = {30'h0000_0000, variant_q};
        end else if (apb_req.paddr == OFS_COUNTS) begin
            rdata_d = {rejected_cnt_q, applied_cnt_q};
            err_d = apb_req.pwrite;
        end else if (apb_req.paddr == OFS_LAST_FRAME) begin
            rdata_d = last_frame_q;
            err_d = apb_req.pwrite;
        end else if (apb_req.paddr >= OFS_INPUT_BASE && apb_req.paddr < OFS_INPUT_BASE + 8'(4 * NUM_CHANNELS)) begin
            rdata_d = {16'h0000, in_q[3'(apb_req.paddr[4:2])]};
            err_d = apb_req.pwrite;
        end else if (apb_req.paddr >= OFS_OUTPUT_BASE && apb_req.paddr < OFS_OUTPUT_BASE + 8'(4 * NUM_CHANNELS)) begin
            rdata_d = {16'h0000, out_q[3'(apb_req.paddr[4:2])]};
            err_d = apb_req.pwrite;
        end else begin
            err_d = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rsp_q <= '0;
        end else if (setup_phase) begin
            rsp_q.pready <= 1'b1;
            rsp_q.pslverr <= err_d;
            rsp_q.prdata <= apb_req.pwrite ? 32'h0000_0000 : rdata_d;
        end else begin
            rsp_q <= '0;
        end
    end

    assign apb_rsp = rsp_q;

    // variant steers field extraction; value 3 falls back to the 16-bit layout
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            variant_q <= RST_VARIANT;
        end else if (do_write && apb_req.paddr == OFS_CTRL) begin
            variant_q <= apb_req.pwdata[1:0]; // [R1] [R2] [R3]
        end
    end

endmodule : dac_write_update_decoder
`default_nettype wire

// File: dac_write_update_decoder_bench.sv
/* self-checking bench: apb master tasks plus frame scenarios against a channel model
   assumes link_host as the serial far side */
`timescale 1ns/1ps
`default_nettype none
module dac_write_update_decoder_bench;
    import dac_cmd_pkg::*;
    logic pclk, presetn, sclk, sync_n, sdin, er;
    apb_req_t req;
    apb_rsp_t rsp;
    logic [NUM_CH-1:0][CODE_W-1:0] code;
    logic [CODE_W-1:0] in_m [NUM_CH];
    logic [CODE_W-1:0] out_m [NUM_CH];
    logic [31:0] rd;
    int error_cnt = 0;
    int num_checks = 0;
    int var_m = 0;
    dac_write_update_decoder #(.NUM_CHANNELS(NUM_CH)) dut_u (.pclk(pclk), .presetn(presetn), .apb_req(req),
        .apb_rsp(rsp), .sclk(sclk), .sync_n(sync_n), .sdin(sdin), .dac_code(code));
    link_host link_u (.sclk(sclk), .sync_n(sync_n), .sdin(sdin));
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    task automatic summarize();
        if (error_cnt == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : summarize
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk
    // ready, data and error are taken at the rising edge that completes the access
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        logic rdy;
        k = 0;
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        req.penable <= 1'b1;
        do begin
            @(posedge pclk);
            rdy = rsp.pready;
            rd = rsp.prdata;
            er = rsp.pslverr;
            k++;
        end while (rdy !== 1'b1 && k < 20);
        if (rdy !== 1'b1) error_cnt++;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer
    task automatic go(input logic t, input logic [3:0] c, input logic [3:0] a, input logic [15:0] f, input int nb);
        logic [15:0] v;
        v = f >> (2 * var_m);
        link_u.send({t, 3'h5, c, a, f, ~a}, nb);
        if (nb == 32 && !t && (c == CMD_WRITE_UPDATE_ALL || c == CMD_WRITE_UPDATE_ONE))
            for (int i = 0; i < NUM_CH; i++)
                if (a == ADDR_BROADCAST || a == 4'(i)) begin
                    in_m[i] = v;
                    out_m[i] = v;
                end else if (c == CMD_WRITE_UPDATE_ALL && !a[3]) begin
                    out_m[i] = in_m[i];
                end
        repeat (6) @(posedge pclk);
        for (int i = 0; i < NUM_CH; i++) begin
            chk("dac_code", 32'(out_m[i]), 32'(code[i]));
            xfer(1'b0, OFS_INPUT_BASE + 8'(4 * i), 32'h0);
            chk("input", 32'(in_m[i]), rd);
        end
    endtask : go
    initial begin
        #200000;
        error_cnt++;
        summarize();
    end
    initial begin
        presetn = 1'b0;
        req = '0;
        in_m = '{default: 16'h0000};
        out_m = '{default: 16'h0000};
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        xfer(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl", 32'(RST_VARIANT), rd);
        xfer(1'b0, 8'h3C, 32'h0);
        chk("unmapped", 32'h1, 32'(er));
        xfer(1'b1, OFS_COUNTS, 32'h1);
        chk("ro write", 32'h1, 32'(er));
        xfer(1'b0, 8'h41, 32'h0);
        chk("unaligned", 32'h1, 32'(er));
        go(1'b0, CMD_WRITE_UPDATE_ONE, 4'h0, 16'hFFFF, 0);
        for (int i = 0; i < NUM_CH; i++)
            go(1'b0, CMD_WRITE_UPDATE_ONE, 4'(i), 16'hA5C0 + 16'(i * 257), 32);
        go(1'b0, CMD_WRITE_UPDATE_ALL, 4'h3, 16'h1234, 32);
        for (int a = 8; a < 15; a++) begin
            go(1'b0, CMD_WRITE_UPDATE_ALL, 4'(a), 16'hFFFF, 32);
            go(1'b0, CMD_WRITE_UPDATE_ONE, 4'(a), 16'h0F0F, 32);
        end
        go(1'b0, CMD_WRITE_UPDATE_ONE, 4'h5, 16'hBEEF, 31);
        go(1'b1, CMD_WRITE_UPDATE_ONE, 4'h5, 16'hBEEF, 32);
        go(1'b0, CMD_WRITE_UPDATE_ALL, ADDR_BROADCAST, 16'h8001, 32);
        for (int m = 1; m < 3; m++) begin
            xfer(1'b1, OFS_CTRL, 32'(m));
            var_m = m;
            go(1'b0, CMD_WRITE_UPDATE_ONE, 4'h6, 16'hC3FF, 32);
            go(1'b0, CMD_WRITE_UPDATE_ONE, ADDR_BROADCAST, 16'h9ABF, 32);
        end
        xfer(1'b1, OFS_CTRL, 32'h3);
        xfer(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl", 32'h3, rd);
        var_m = 0;
        go(1'b0, CMD_WRITE_UPDATE_ONE, 4'h2, 16'h5A5F, 32);
        xfer(1'b0, OFS_OUTPUT_BASE + 8'h1C, 32'h0);
        chk("output", 32'(out_m[7]), rd);
        summarize();
    end
endmodule : dac_write_update_decoder_bench
`default_nettype wire

// File: dwud_sva.sv
/* apb handshake and link-quiet checks on the decoder top ports
   assumes bind into dac_write_update_decoder */
`timescale 1ns/1ps
`default_nettype none
module dwud_checker
    import dac_cmd_pkg::*;
#(
    parameter int NUM_CHANNELS = NUM_CH
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire apb_req_t apb_req,
    input wire apb_rsp_t apb_rsp,
    input wire logic sclk,
    input wire logic sync_n,
    input wire logic sdin,
    input wire logic [NUM_CHANNELS-1:0][CODE_W-1:0] dac_code
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        apb_req.psel && !apb_req.penable;
    endsequence
    // eight quiet edges cover the 3-4 edge apply delay with margin
    sequence s_link_quiet;
        sync_n [*8];
    endsequence
    a_setup_ready: assert property (s_setup |=> apb_rsp.pready)
        else $error("no ready after setup");
    a_ready_single: assert property (apb_rsp.pready |=> !apb_rsp.pready)
        else $error("ready held too long");
    a_idle_quiet: assert property (!apb_req.psel |=> !apb_rsp.pready)
        else $error("ready without request");
    a_err_ready: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
        else $error("error without ready");
    a_write_zero: assert property (apb_rsp.pready && apb_req.pwrite |-> apb_rsp.prdata == 32'h0)
        else $error("read data on write");
    a_unaligned_err: assert property (s_setup ##0 apb_req.paddr[1:0] != 2'h0 |=> apb_rsp.pslverr)
        else $error("unaligned access accepted");
    a_ro_write: assert property (s_setup ##0 apb_req.pwrite && apb_req.paddr == OFS_COUNTS |=> apb_rsp.pslverr)
        else $error("read-only write accepted");
    a_ctrl_ok: assert property (s_setup ##0 apb_req.paddr == OFS_CTRL |=> !apb_rsp.pslverr)
        else $error("control access refused");
    a_code_quiet: assert property (s_link_quiet |-> $stable(dac_code))
        else $error("code changed with no frame");
endmodule : dwud_checker
bind dac_write_update_decoder dwud_checker #(.NUM_CHANNELS(NUM_CHANNELS)) chk_u (.pclk(pclk),
    .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp), .sclk(sclk), .sync_n(sync_n),
    .sdin(sdin), .dac_code(dac_code));
`default_nettype wire

// File: frame_shifter.sv
/*
 * Link-side serial receiver: shifts a 32-bit frame on the link clock while frame sync is low
 * and hands each complete frame over as a held word plus a toggle.
 * Assumes sync_n and sdin change away from the rising edge of sclk, and that sclk may stop between frames.
 */
`timescale 1ns/1ps
`default_nettype none
module frame_shifter
    import dac_cmd_pkg::*;
(
    input wire logic sclk,
    input wire logic presetn,
    input wire logic sync_n,
    input wire logic sdin,
    output logic [FRAME_BITS-1:0] frame_word_q,
    output logic frame_toggle_q
);

    logic [5:0] bit_cnt_q;
    logic [FRAME_BITS-1:0] shift_q;
    logic cnt_clr;

    // sync high ends a frame even with sclk stopped, so a short frame leaves nothing behind
    assign cnt_clr = sync_n | ~presetn;

    always_ff @(posedge sclk or posedge cnt_clr) begin
        if (cnt_clr) begin
            bit_cnt_q <= 6'h00; // [R10]
        end else if (bit_cnt_q != 6'(FRAME_BITS)) begin
            bit_cnt_q <= bit_cnt_q + 6'h01;
        end
    end

    always_ff @(posedge sclk or negedge presetn) begin
        if (!presetn) begin
            shift_q <= '0;
        end else if (!sync_n && bit_cnt_q != 6'(FRAME_BITS)) begin
            shift_q <= {shift_q[FRAME_BITS-2:0], sdin};
        end
    end

    // word is held until the next full frame, at least 32 link clocks, so the toggle qualifies it
    always_ff @(posedge sclk or negedge presetn) begin
        if (!presetn) begin
            frame_word_q <= '0;
            frame_toggle_q <= 1'b0;
        end else if (!sync_n && bit_cnt_q == 6'(FRAME_BITS - 1)) begin
            frame_word_q <= {shift_q[FRAME_BITS-2:0], sdin}; // [R10]
            frame_toggle_q <= ~frame_toggle_q;
        end
    end

endmodule : frame_shifter
`default_nettype wire

// File: link_host.sv
/* serial host model: sends one frame, msb first, on a 6 ns link clock
   assumes the caller spaces frames; sclk stands low between frames */
`timescale 1ns/1ps
`default_nettype none
module link_host (
    output logic sclk,
    output logic sync_n,
    output logic sdin
);
    initial begin
        sclk = 1'b0;
        sync_n = 1'b1;
        sdin = 1'b0;
    end
    // nb below 32 cuts the frame short
    task automatic send(input logic [31:0] w, input int nb);
        #1.7 sync_n = 1'b0;
        for (int i = 31; i > 31 - nb; i--) begin
            sdin = w[i];
            #3 sclk = 1'b1;
            #3 sclk = 1'b0;
        end
        #2 sync_n = 1'b1;
        // released line must not keep its last value
        sdin = ~sdin;
    endtask : send
endmodule : link_host
`default_nettype wire
